//--- logic/ppim_defines.vh
// Constants for the PSE power indicator and MPS block
`ifndef PPIM_DEFINES_VH
`define PPIM_DEFINES_VH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define PPIM_CLK_KHZ 40000
`define PPIM_CLK_MHZ 40
// Indicator enable delay after the inrush-done release
`define PPIM_IND_DELAY_MS 24
// 24 ms at 40 MHz, sized to the 20-bit delay counter
`define PPIM_IND_DELAY_CYC 20'd960000
// Pulse time base tick
`define PPIM_MPS_TICK_NS 1000
`define PPIM_MPS_TICK_CYC ((`PPIM_MPS_TICK_NS * `PPIM_CLK_MHZ) / 1000)
// Last count of the tick divider, at the divider's own width
`define PPIM_MPS_TICK_LAST 6'd39
// Pulse period and high times, in ticks (per mille of period)
`define PPIM_MPS_PERIOD 10'd1000
`define PPIM_MPS_HI_26 10'd260
`define PPIM_MPS_HI_125 10'd125
`define PPIM_MPS_HI_81 10'd81
`define PPIM_MPS_HI_54 10'd54

// ----------------------------------------------------------------
// Duty selection codes
// ----------------------------------------------------------------
`define PPIM_DUTY_26 2'd0
`define PPIM_DUTY_125 2'd1
`define PPIM_DUTY_81 2'd2
`define PPIM_DUTY_54 2'd3

// ----------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------
`define PPIM_REG_CTRL 8'h00
`define PPIM_REG_STATUS 8'h04
`define PPIM_REG_EVENTS 8'h08
`define PPIM_CTRL_RESET 2'h3
`define PPIM_CTRL_MPS_EN 0
`define PPIM_CTRL_IND_EN 1
`define PPIM_RESP_OKAY 2'h0
`define PPIM_RESP_SLVERR 2'h2
`define PPIM_CLASS_MAX 3'd5

`endif

//--- logic/ppim_tier_enc.v
// Encoder from class event count and PSE type to indicator flags
`timescale 1ns/1ps
module ppim_tier_enc (
	// Stored classification state
	input wire [2:0] class_count_i,
	input wire type34_i,
	// Flag levels, 1 means released (high)
	output reg power_tier_high_flag_o,
	output reg power_tier_low_flag_o,
	output reg enhanced_pse_flag_o
);

// ----------------------------------------------------------------
// Encoding table
// ----------------------------------------------------------------
// Count of zero is read as one event, the least a PSE can give
always @* begin
	power_tier_high_flag_o = 1'b1;
	power_tier_low_flag_o = 1'b1;
	enhanced_pse_flag_o = ~type34_i;
	if (!type34_i) begin
		power_tier_low_flag_o = (class_count_i < 3'd2);
	end else begin
		case (class_count_i)
			3'd0, 3'd1: begin
				power_tier_high_flag_o = 1'b1;
				power_tier_low_flag_o = 1'b1;
			end
			3'd2, 3'd3: begin
				power_tier_high_flag_o = 1'b1;
				power_tier_low_flag_o = 1'b0;
			end
			3'd4: begin
				power_tier_high_flag_o = 1'b0;
				power_tier_low_flag_o = 1'b1;
			end
			default: begin
				power_tier_high_flag_o = 1'b0;
				power_tier_low_flag_o = 1'b0;
			end
		endcase
	end
end

endmodule

//--- logic/ppim_mps_gen.v
// Maintain-power pulse generator on a fixed time base
`timescale 1ns/1ps
`include "ppim_defines.vh"
module ppim_mps_gen (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Control
	input wire enable_i,
	input wire [1:0] duty_sel_i,
	// Pulse
	output reg pulse_o
);

reg [5:0] tick_cnt;
reg [9:0] phase_cnt;
reg [9:0] hi_len;
reg [9:0] next_hi_len;
wire tick;

assign tick = (tick_cnt == `PPIM_MPS_TICK_LAST);

// High time for the selected ratio
always @* begin
	case (duty_sel_i)
		`PPIM_DUTY_26: next_hi_len = `PPIM_MPS_HI_26;
		`PPIM_DUTY_125: next_hi_len = `PPIM_MPS_HI_125;
		`PPIM_DUTY_81: next_hi_len = `PPIM_MPS_HI_81;
		default: next_hi_len = `PPIM_MPS_HI_54;
	endcase
end

// period and high time from the tick
// Ratio is latched per period so a change never cuts a pulse short
always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		tick_cnt <= 6'h00;
		phase_cnt <= 10'h000;
		hi_len <= 10'h000;
		pulse_o <= 1'b0;
	end else if (!enable_i) begin
		tick_cnt <= 6'h00;
		phase_cnt <= 10'h000;
		hi_len <= next_hi_len;
		pulse_o <= 1'b0;
	end else begin
		tick_cnt <= tick ? 6'h00 : tick_cnt + 6'h01;
		if (tick) begin
			if (phase_cnt == `PPIM_MPS_PERIOD - 10'd1) begin
				phase_cnt <= 10'h000;
				hi_len <= next_hi_len;
			end else begin
				phase_cnt <= phase_cnt + 10'h001;
			end
		end
		pulse_o <= (phase_cnt < hi_len);
	end
end

endmodule

//--- logic/ppim_top.v
// PSE power indicators, inrush-done pin and automatic MPS pulses
//
// Notes on behaviour
// - Indicators show allocated power from class event count and PSE type.
// - Indicators stay released until 24 ms after inrush-done is released.
// - Indicators release on thermal shutdown or input below about 32 V.
// - Stored indicator state survives those events while above mark reset.
// - Stored indicator state clears when input drops below mark reset.
// - Type 1-2: enhanced and high flags high; low flag low after two events.
// - Type 3-4: enhanced low; tiers 11, 10 at 2-3, 01 at 4, 00 at 5.
// - Encoding follows events actually received, not the requested class.
// - MPS pulses run automatically only while return current is below 28 mA.
// - Type 3-4 duty from strap: short 12.5%, resistor 8.1%, open 5.4%.
// - Type 1-2 uses fixed 26% duty, strap ignored.
// - Re-enter inrush after undervoltage recovery or thermal recovery.
// - Inrush-done pin pulled low only during inrush, released otherwise.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "ppim_defines.vh"
module ppim_top #(
	parameter [19:0] IND_DELAY_CYC = `PPIM_IND_DELAY_CYC
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// AXI4-Lite write address and data
	input wire [7:0] axi_awaddr_i,
	input wire axi_awvalid_i,
	output reg axi_awready_o,
	input wire [31:0] axi_wdata_i,
	input wire [3:0] axi_wstrb_i,
	input wire axi_wvalid_i,
	output reg axi_wready_o,
	// AXI4-Lite write response
	output reg [1:0] axi_bresp_o,
	output reg axi_bvalid_o,
	input wire axi_bready_i,
	// AXI4-Lite read
	input wire [7:0] axi_araddr_i,
	input wire axi_arvalid_i,
	output reg axi_arready_o,
	output reg [31:0] axi_rdata_o,
	output reg [1:0] axi_rresp_o,
	output reg axi_rvalid_o,
	input wire axi_rready_i,
	// Analog front end indications
	input wire class_event_i,
	input wire pse_type34_i,
	input wire above_uvlo_i,
	input wire above_32v_i,
	input wire above_mark_i,
	input wire thermal_sd_i,
	input wire inrush_end_i,
	input wire load_return_low_i,
	// Duty strap decode
	input wire pulse_duty_strap_short_i,
	input wire pulse_duty_strap_res_i,
	// Open-drain indicator and inrush-done pins
	output reg power_tier_high_flag_o,
	output reg power_tier_high_flag_oe_n_o,
	output reg power_tier_low_flag_o,
	output reg power_tier_low_flag_oe_n_o,
	output reg enhanced_pse_flag_o,
	output reg enhanced_pse_flag_oe_n_o,
	output reg inrush_done_output_o,
	output reg inrush_done_output_oe_n_o,
	// Maintain-power pulse
	output wire mps_pulse_output_o
);

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
localparam [1:0] PH_OFF = 2'd0;
localparam [1:0] PH_INRUSH = 2'd1;
localparam [1:0] PH_DELAY = 2'd2;
localparam [1:0] PH_RUN = 2'd3;

reg [1:0] phase;
reg [1:0] next_phase;
reg [19:0] delay_cnt;
reg [2:0] class_count;
reg type34;
reg [1:0] strap_sel;
reg strap_taken;
reg [1:0] ctrl;
reg [2:0] events;
reg aw_full;
reg w_full;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
reg [1:0] duty_sel;
reg [31:0] rd_word;
reg rd_hit;
wire enc_high;
wire enc_low;
wire enc_bt;
wire ind_on;
wire power_bad;
wire mps_run;
wire wr_fire;
wire wr_ctrl;
wire wr_events;

assign power_bad = !above_uvlo_i || thermal_sd_i;
assign wr_fire = aw_full && w_full && !axi_bvalid_o;
assign wr_ctrl = wr_fire && (aw_addr == `PPIM_REG_CTRL);
assign wr_events = wr_fire && (aw_addr == `PPIM_REG_EVENTS);

// ----------------------------------------------------------------
// Power phase sequence
// ----------------------------------------------------------------
// any loss of supply or heat drops to off, recovery restarts inrush
always @* begin
	next_phase = phase;
	case (phase)
		PH_OFF: begin
			if (!power_bad)
				next_phase = PH_INRUSH;
		end
		PH_INRUSH: begin
			if (power_bad)
				next_phase = PH_OFF;
			else if (inrush_end_i)
				next_phase = PH_DELAY;
		end
		PH_DELAY: begin
			if (power_bad)
				next_phase = PH_OFF;
			else if (delay_cnt == IND_DELAY_CYC - 20'd1)
				next_phase = PH_RUN;
		end
		PH_RUN: begin
			if (power_bad)
				next_phase = PH_OFF;
		end
		default: next_phase = PH_OFF;
	endcase
end

// Phase register and enable delay counter
always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		phase <= PH_OFF;
		delay_cnt <= 20'h00000;
	end else begin
		phase <= next_phase;
		// count 24 ms from the inrush-done release
		if (phase == PH_DELAY)
			delay_cnt <= delay_cnt + 20'h00001;
		else
			delay_cnt <= 20'h00000;
	end
end

// ----------------------------------------------------------------
// Stored classification state
// ----------------------------------------------------------------
// Events are only counted while unpowered, as classification ends
// before the supply reaches lockout
always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		class_count <= 3'd0;
		type34 <= 1'b0;
	end else if (!above_mark_i) begin
		class_count <= 3'd0;
		type34 <= 1'b0;
	end else if (class_event_i && phase == PH_OFF) begin
		if (class_count != `PPIM_CLASS_MAX)
			class_count <= class_count + 3'd1;
		type34 <= pse_type34_i;
	end
end

ppim_tier_enc u_enc (
	.class_count_i(class_count),
	.type34_i(type34),
	.power_tier_high_flag_o(enc_high),
	.power_tier_low_flag_o(enc_low),
	.enhanced_pse_flag_o(enc_bt)
);

// ----------------------------------------------------------------
// Indicator and inrush-done pins
// ----------------------------------------------------------------
// release on low input or heat; state kept, pins re-driven
assign ind_on = (phase == PH_RUN) && above_32v_i && !thermal_sd_i &&
	ctrl[`PPIM_CTRL_IND_EN];

// Open drain: a high flag is a released pin, a low flag pulls down
always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		power_tier_high_flag_o <= 1'b0;
		power_tier_high_flag_oe_n_o <= 1'b1;
		power_tier_low_flag_o <= 1'b0;
		power_tier_low_flag_oe_n_o <= 1'b1;
		enhanced_pse_flag_o <= 1'b0;
		enhanced_pse_flag_oe_n_o <= 1'b1;
		inrush_done_output_o <= 1'b0;
		inrush_done_output_oe_n_o <= 1'b1;
	end else begin
		// indicators wait for the run phase
		power_tier_high_flag_oe_n_o <= !(ind_on && !enc_high);
		power_tier_low_flag_oe_n_o <= !(ind_on && !enc_low);
		enhanced_pse_flag_oe_n_o <= !(ind_on && !enc_bt);
		inrush_done_output_oe_n_o <= !(next_phase == PH_INRUSH);
	end
end

// ----------------------------------------------------------------
// Duty strap and maintain-power pulses
// ----------------------------------------------------------------
// Strap is caught once after reset release; it is a board level
always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		strap_sel <= `PPIM_DUTY_54;
		strap_taken <= 1'b0;
	end else if (!strap_taken) begin
		strap_taken <= 1'b1;
		if (pulse_duty_strap_short_i)
			strap_sel <= `PPIM_DUTY_125;
		else if (pulse_duty_strap_res_i)
			strap_sel <= `PPIM_DUTY_81;
		else
			strap_sel <= `PPIM_DUTY_54;
	end
end

always @* begin
	if (type34)
		duty_sel = strap_sel;
	else
		duty_sel = `PPIM_DUTY_26;
end

// pulse only while return current is low and powered
assign mps_run = load_return_low_i && ctrl[`PPIM_CTRL_MPS_EN] &&
	(phase == PH_DELAY || phase == PH_RUN);

// pulses from the fixed time base
ppim_mps_gen u_mps (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.enable_i(mps_run),
	.duty_sel_i(duty_sel),
	.pulse_o(mps_pulse_output_o)
);

// ----------------------------------------------------------------
// Sticky event record
// ----------------------------------------------------------------
// Bit 0 thermal, bit 1 below 32 V, bit 2 below lockout; write one to
// clear, and a new event in the same cycle wins over the clear
always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		events <= 3'h0;
	end else begin
		events <= (events & ~(wr_events && w_strb[0] ?
			w_data[2:0] : 3'h0)) |
			{!above_uvlo_i, !above_32v_i, thermal_sd_i};
	end
end

// ----------------------------------------------------------------
// AXI4-Lite write path
// ----------------------------------------------------------------
// Address and data are taken in either order; the response follows
// once both are held, and a new pair waits for the response to go
always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		axi_awready_o <= 1'b0;
		axi_wready_o <= 1'b0;
		axi_bvalid_o <= 1'b0;
		axi_bresp_o <= `PPIM_RESP_OKAY;
		aw_full <= 1'b0;
		w_full <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		ctrl <= `PPIM_CTRL_RESET;
	end else begin
		axi_awready_o <= axi_awvalid_i && !axi_awready_o &&
			!aw_full && !axi_bvalid_o;
		axi_wready_o <= axi_wvalid_i && !axi_wready_o &&
			!w_full && !axi_bvalid_o;
		if (axi_awvalid_i && axi_awready_o) begin
			aw_full <= 1'b1;
			aw_addr <= {axi_awaddr_i[7:2], 2'b00};
		end
		if (axi_wvalid_i && axi_wready_o) begin
			w_full <= 1'b1;
			w_data <= axi_wdata_i;
			w_strb <= axi_wstrb_i;
		end
		if (wr_fire) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			axi_bvalid_o <= 1'b1;
			if (wr_ctrl || wr_events)
				axi_bresp_o <= `PPIM_RESP_OKAY;
			else
				axi_bresp_o <= `PPIM_RESP_SLVERR;
			if (wr_ctrl && w_strb[0])
				ctrl <= w_data[1:0];
		end else if (axi_bvalid_o && axi_bready_i) begin
			axi_bvalid_o <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// AXI4-Lite read path
// ----------------------------------------------------------------
// Read mux; status reflects live block state
always @* begin
	rd_word = 32'h00000000;
	rd_hit = 1'b1;
	case ({axi_araddr_i[7:2], 2'b00})
		`PPIM_REG_CTRL: rd_word[1:0] = ctrl;
		`PPIM_REG_STATUS: begin
			rd_word[2:0] = class_count;
			rd_word[3] = type34;
			rd_word[5:4] = phase;
			rd_word[6] = enc_high;
			rd_word[7] = enc_low;
			rd_word[8] = enc_bt;
			rd_word[10:9] = duty_sel;
			rd_word[11] = mps_pulse_output_o;
			rd_word[12] = ind_on;
		end
		`PPIM_REG_EVENTS: rd_word[2:0] = events;
		default: rd_hit = 1'b0;
	endcase
end

// One read at a time; data held until the master takes it
always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		axi_arready_o <= 1'b0;
		axi_rvalid_o <= 1'b0;
		axi_rdata_o <= 32'h00000000;
		axi_rresp_o <= `PPIM_RESP_OKAY;
	end else begin
		axi_arready_o <= axi_arvalid_i && !axi_arready_o &&
			!axi_rvalid_o;
		if (axi_arvalid_i && axi_arready_o) begin
			axi_rvalid_o <= 1'b1;
			axi_rdata_o <= rd_word;
			axi_rresp_o <= rd_hit ? `PPIM_RESP_OKAY :
				`PPIM_RESP_SLVERR;
		end else if (axi_rvalid_o && axi_rready_i) begin
			axi_rvalid_o <= 1'b0;
		end
	end
end

endmodule

//--- test/ppim_top_asserts.sv
// Port-level checks for the power indicator and MPS block
`timescale 1ns/1ps
module ppim_top_asserts #(
	parameter [19:0] IND_DELAY_CYC = 20'd20
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Front end levels
	input wire above_uvlo_i,
	input wire above_32v_i,
	input wire thermal_sd_i,
	input wire load_return_low_i,
	// Bus answers
	input wire axi_bvalid_o,
	input wire axi_bready_i,
	input wire axi_rvalid_o,
	input wire axi_rready_i,
	// Pins
	input wire power_tier_high_flag_oe_n_o,
	input wire power_tier_low_flag_oe_n_o,
	input wire enhanced_pse_flag_oe_n_o,
	input wire inrush_done_output_oe_n_o,
	input wire mps_pulse_output_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// All three indicators released
	wire rel = power_tier_high_flag_oe_n_o & power_tier_low_flag_oe_n_o &
		enhanced_pse_flag_oe_n_o;
	reg [19:0] dly_cnt;
	reg prev_oe_n;
	// Cycles since inrush release, zero when idle; the previous level
	// resets to released so leaving reset gives no false edge
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dly_cnt <= 20'h0;
			prev_oe_n <= 1'b1;
		end else begin
			prev_oe_n <= inrush_done_output_oe_n_o;
			if (inrush_done_output_oe_n_o && !prev_oe_n)
				dly_cnt <= 20'h1;
			else if (dly_cnt != 20'h0 && dly_cnt < IND_DELAY_CYC)
				dly_cnt <= dly_cnt + 20'h1;
			else
				dly_cnt <= 20'h0;
		end
	end
	a_inrush_drop:
	assert property (!above_uvlo_i |=> inrush_done_output_oe_n_o)
		else $error("inrush pin held low below lockout");
	a_uvlo_reentry:
	assert property (!above_uvlo_i ##1 above_uvlo_i && !thermal_sd_i
		|=> !inrush_done_output_oe_n_o) else $error("no inrush after lockout");
	a_thermal_reentry:
	assert property (thermal_sd_i ##1 !thermal_sd_i && above_uvlo_i
		|=> !inrush_done_output_oe_n_o) else $error("no inrush after thermal");
	a_thermal_release:
	assert property (thermal_sd_i |-> ##2 rel)
		else $error("indicators driven in thermal shutdown");
	a_low_release:
	assert property (!above_32v_i ##1 !above_32v_i |=> rel)
		else $error("indicators driven below 32 V");
	a_enable_delay:
	assert property (dly_cnt != 20'h0 && dly_cnt < IND_DELAY_CYC - 20'd2
		|-> rel) else $error("indicators driven before delay");
	a_mps_high_load:
	assert property (!load_return_low_i [*3] |-> !mps_pulse_output_o)
		else $error("pulse with high return current");
	a_write_answer:
	assert property (axi_bvalid_o && axi_bready_i |=> !axi_bvalid_o)
		else $error("write response not retired");
	a_read_answer:
	assert property (axi_rvalid_o && axi_rready_i |=> !axi_rvalid_o)
		else $error("read response not retired");
endmodule
bind ppim_top ppim_top_asserts #(.IND_DELAY_CYC(IND_DELAY_CYC)) u_chk (
	.clk_i, .rst_i, .above_uvlo_i, .above_32v_i, .thermal_sd_i,
	.load_return_low_i, .axi_bvalid_o, .axi_bready_i, .axi_rvalid_o,
	.axi_rready_i, .power_tier_high_flag_oe_n_o, .power_tier_low_flag_oe_n_o,
	.enhanced_pse_flag_oe_n_o, .inrush_done_output_oe_n_o, .mps_pulse_output_o
);

//--- test/ppim_pse_model.sv
// Power sourcing equipment model sending classification events
`timescale 1ns/1ps
module ppim_pse_model (
	// Clock
	input wire clk_i,
	// Toward the device
	output reg class_event_o,
	output reg pse_type34_o
);
	initial begin
		class_event_o = 1'h0;
		pse_type34_o = 1'h0;
	end
	// Type line inverted between events so stray sampling shows up
	task classify(input [2:0] n, input logic t, input integer gap);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1) begin
				@(posedge clk_i);
				class_event_o <= 1'h1;
				pse_type34_o <= t;
				@(posedge clk_i);
				class_event_o <= 1'h0;
				pse_type34_o <= ~t;
				repeat (gap) @(posedge clk_i);
			end
		end
	endtask
endmodule

//--- test/ppim_top_tb.sv
// Self-checking bench for the power indicator and MPS block
`timescale 1ns/1ps
module ppim_top_tb;
	localparam [19:0] DLY = 20'd20;
	logic clk_i = 1'h0, rst_i = 1'h1;
	logic [7:0] axi_awaddr_i = 8'h0, axi_araddr_i = 8'h0;
	logic [31:0] axi_wdata_i = 32'h0;
	logic [3:0] axi_wstrb_i = 4'hf;
	logic axi_awvalid_i = 1'h0, axi_wvalid_i = 1'h0, axi_bready_i = 1'h0;
	logic axi_arvalid_i = 1'h0, axi_rready_i = 1'h0;
	logic above_uvlo_i = 1'h0, above_32v_i = 1'h1, above_mark_i = 1'h0;
	logic thermal_sd_i = 1'h0, inrush_end_i = 1'h0, load_return_low_i = 1'h0;
	logic pulse_duty_strap_short_i = 1'h0, pulse_duty_strap_res_i = 1'h0;
	wire class_event_i, pse_type34_i, axi_awready_o, axi_wready_o;
	wire axi_bvalid_o, axi_arready_o, axi_rvalid_o, mps_pulse_output_o;
	wire [1:0] axi_bresp_o, axi_rresp_o;
	wire [31:0] axi_rdata_o;
	wire power_tier_high_flag_oe_n_o, power_tier_low_flag_oe_n_o;
	wire enhanced_pse_flag_oe_n_o, inrush_done_output_oe_n_o;
	wire [3:0] lvl;
	wire [2:0] pins = {power_tier_high_flag_oe_n_o,
		power_tier_low_flag_oe_n_o, enhanced_pse_flag_oe_n_o};
	integer fail_count = 0, check_count = 0, k, w;
	logic [31:0] d;
	logic [1:0] r;
	// Rows: type34, event count, expected high/low/enhanced levels
	logic [7:0] rows [0:8] = '{8'h07, 8'h17, 8'h25, 8'h96, 8'ha4,
		8'hb4, 8'hc2, 8'hd0, 8'he0};
	ppim_top #(.IND_DELAY_CYC(DLY)) dut (.clk_i, .rst_i, .axi_awaddr_i,
		.axi_awvalid_i, .axi_awready_o, .axi_wdata_i, .axi_wstrb_i,
		.axi_wvalid_i, .axi_wready_o, .axi_bresp_o, .axi_bvalid_o,
		.axi_bready_i, .axi_araddr_i, .axi_arvalid_i, .axi_arready_o,
		.axi_rdata_o, .axi_rresp_o, .axi_rvalid_o, .axi_rready_i,
		.class_event_i, .pse_type34_i, .above_uvlo_i, .above_32v_i,
		.above_mark_i, .thermal_sd_i, .inrush_end_i, .load_return_low_i,
		.pulse_duty_strap_short_i, .pulse_duty_strap_res_i,
		.power_tier_high_flag_o(lvl[3]), .power_tier_high_flag_oe_n_o,
		.power_tier_low_flag_o(lvl[2]), .power_tier_low_flag_oe_n_o,
		.enhanced_pse_flag_o(lvl[1]), .enhanced_pse_flag_oe_n_o,
		.inrush_done_output_o(lvl[0]), .inrush_done_output_oe_n_o,
		.mps_pulse_output_o);
	ppim_pse_model pse (.clk_i, .class_event_o(class_event_i),
		.pse_type34_o(pse_type34_i));
	initial forever #12.5 clk_i = ~clk_i;
	// -------------------------------
	// Helpers
	// -------------------------------
	task chk(input [31:0] got, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", check_count, fail_count);
			if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
			else $display("== FAILED ==");
			$finish;
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		begin
			@(posedge clk_i);
			axi_awaddr_i <= a;
			axi_wdata_i <= v;
			axi_awvalid_i <= 1'h1;
			axi_wvalid_i <= 1'h1;
			axi_bready_i <= 1'h1;
			do begin
				@(posedge clk_i);
				if (axi_awready_o) axi_awvalid_i <= 1'h0;
				if (axi_wready_o) axi_wvalid_i <= 1'h0;
			end while (axi_bvalid_o !== 1'h1);
			r = axi_bresp_o;
			axi_bready_i <= 1'h0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge clk_i);
			axi_araddr_i <= a;
			axi_arvalid_i <= 1'h1;
			axi_rready_i <= 1'h1;
			do begin
				@(posedge clk_i);
				if (axi_arready_o) axi_arvalid_i <= 1'h0;
			end while (axi_rvalid_o !== 1'h1);
			d = axi_rdata_o;
			r = axi_rresp_o;
			axi_rready_i <= 1'h0;
		end
	endtask
	// Power off, clear state, classify, then run through startup
	task power_up(input [2:0] n, input logic t);
		begin
			above_uvlo_i <= 1'h0;
			above_mark_i <= 1'h0;
			inrush_end_i <= 1'h0;
			load_return_low_i <= 1'h0;
			repeat (2) @(posedge clk_i);
			above_mark_i <= 1'h1;
			pse.classify(n, t, n % 3);
			@(posedge clk_i);
			above_uvlo_i <= 1'h1;
			repeat (3) @(posedge clk_i);
			chk(inrush_done_output_oe_n_o, 1'h0);
			inrush_end_i <= 1'h1;
			repeat (DLY / 2) @(posedge clk_i);
			chk(pins, 3'h7);
			repeat (DLY / 2 + 6) @(posedge clk_i);
			chk(inrush_done_output_oe_n_o, 1'h1);
		end
	endtask
	// Reset with a strap setting, start pulsing, measure high time
	task mps(input logic s, input logic rs, input logic t, input integer hi);
		begin
			pulse_duty_strap_short_i <= s;
			pulse_duty_strap_res_i <= rs;
			rst_i <= 1'h1;
			repeat (2) @(posedge clk_i);
			rst_i <= 1'h0;
			power_up(3'h2, t);
			load_return_low_i <= 1'h1;
			w = 0;
			while (mps_pulse_output_o !== 1'h1 && w < 100) begin
				@(posedge clk_i);
				w = w + 1;
			end
			w = 0;
			while (mps_pulse_output_o === 1'h1) begin
				@(posedge clk_i);
				w = w + 1;
			end
			chk(w, hi * 40);
		end
	endtask
	// Watchdog sized above the longest pulse runs
	initial begin
		repeat (90000) @(posedge clk_i);
		fail_count = fail_count + 1;
		conclude;
	end
	// -------------------------------
	// Main sequence
	// -------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		rd(8'h00);
		chk(d, 32'h3);
		rd(8'h0c);
		chk({30'h0, r}, 32'h2);
		chk(d, 32'h0);
		wr(8'h04, 32'h0);
		chk({30'h0, r}, 32'h2);
		for (k = 0; k < 9; k = k + 1) begin
			power_up(rows[k][6:4], rows[k][7]);
			chk(pins, rows[k][2:0]);
			// Open-drain pins only ever pull low
			chk(lvl, 4'h0);
			rd(8'h04);
			chk({d[6], d[7], d[8]}, rows[k][2:0]);
			chk(d[2:0], rows[k][6:4] > 3'h5 ? 3'h5 : rows[k][6:4]);
		end
		thermal_sd_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		chk(pins, 3'h7);
		thermal_sd_i <= 1'h0;
		repeat (DLY + 8) @(posedge clk_i);
		chk(pins, 3'h0);
		above_32v_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		chk(pins, 3'h7);
		above_32v_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		chk(pins, 3'h0);
		rd(8'h08);
		chk(d[2:0], 3'h7);
		wr(8'h08, 32'h7);
		rd(8'h08);
		chk(d[2:0], 3'h0);
		power_up(3'h0, 1'h0);
		chk(pins, 3'h7);
		rd(8'h04);
		chk(d[3:0], 4'h0);
		// Strap choices stand in for the board designer's options
		mps(1'h1, 1'h0, 1'h0, 260);
		w = 0;
		while (mps_pulse_output_o !== 1'h1) begin
			@(posedge clk_i);
			w = w + 1;
		end
		chk(w, 29600);
		// high return current stops the pulses
		load_return_low_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		chk(mps_pulse_output_o, 1'h0);
		mps(1'h1, 1'h0, 1'h1, 125);
		mps(1'h0, 1'h1, 1'h1, 81);
		mps(1'h0, 1'h0, 1'h1, 54);
		conclude;
	end
endmodule
